// >>> rtl/mmsp_pkg.sv
// Shared constants, types and layouts of the MAC-side media independent port
package mmsp_pkg;

  // ------------------------------------------------------------------
  // Clocking and management timing
  // ------------------------------------------------------------------
  localparam int CLK_HZ     = 100_000_000;
  localparam int MDC_MAX_HZ = 2_500_000;
  // Half period of the management clock in system cycles, rounded up so the rate never exceeds
  localparam int MDC_HALF   = (CLK_HZ + 2 * MDC_MAX_HZ - 1) / (2 * MDC_MAX_HZ);
  localparam int MDC_CNT_W  = 8;

  // ------------------------------------------------------------------
  // Widths and field positions
  // ------------------------------------------------------------------
  localparam int NIB_W        = 4;
  localparam int FIFO_AW      = 2;
  localparam int ROM_HI_W     = 10;
  localparam int ROM_RXD_LSB  = 0;
  localparam int ROM_RXER_BIT = 4;
  localparam int ROM_RXDV_BIT = 5;
  localparam int ROM_TXD_LSB  = 6;

  // ------------------------------------------------------------------
  // Reset values
  // ------------------------------------------------------------------
  localparam logic RXPOE_IDLE = 1'b1;

  // ------------------------------------------------------------------
  // Types
  // ------------------------------------------------------------------
  typedef struct packed {
    logic             eof;
    logic             err;
    logic [NIB_W-1:0] nib;
  } mmsp_rx_word_t;

  localparam int RX_WORD_W = $bits(mmsp_rx_word_t);

  typedef enum logic [1:0] {
    MG_IDLE,
    MG_LOW,
    MG_HIGH
  } mmsp_mgmt_state_t;

endpackage

// >>> rtl/mmsp_port.sv
// MAC-side media independent port: pin muxing, link-clock crossings and management bit engine
//
// Contract
// - The management clock toward the PHY never runs faster than 2.5 MHz.
// - Management data uses one shared line that each side drives in turn.
// - During a boot-ROM access with the external PHY selected the receive-path output enable tells the PHY to release its pins.
// - During a boot-ROM access the receive and transmit data pins carry upper ROM address bits.
// - Transmit nibbles leave synchronous to the transmit clock, bit 3 most significant.
// - Transmit enable is high exactly in the cycles whose nibble carries frame data.
// - Port outputs stay released unless the external PHY is selected, except the data, receive valid and error pins, which a boot-ROM access drives regardless.
`timescale 1ns/1ps

// ------------------------------------------------------------------
// Dual-clock FIFO with gray pointers
// ------------------------------------------------------------------
module mmsp_afifo #(
  parameter int W  = 4,
  parameter int AW = 2
) (
  input  wire logic         wclk,
  input  wire logic         wrst_n,
  input  wire logic         wce,
  input  wire logic         wen,
  input  wire logic [W-1:0] wdata,
  output logic              wrdy,
  input  wire logic         rclk,
  input  wire logic         rrst_n,
  input  wire logic         rce,
  input  wire logic         ren,
  output logic [W-1:0]      rdata,
  output logic              rvalid
);
  if (AW < 2) begin : g_chk
    $error("mmsp_afifo needs AW of at least 2");
  end

  function automatic logic [AW:0] gray(input logic [AW:0] b);
    return b ^ (b >> 1);
  endfunction

  logic [W-1:0] mem [0:(1<<AW)-1];
  logic [AW:0]  wbin_ff, wgray_ff, rq1_ff, rq2_ff;
  logic [AW:0]  rbin_ff, rgray_ff, wq1_ff, wq2_ff;

  wire          do_wr     = wce & wen & wrdy;
  wire          do_rd     = rce & ren & rvalid;
  wire [AW:0]   nxt_wbin  = wbin_ff + {{AW{1'b0}}, do_wr};
  wire [AW:0]   nxt_wgray = gray(nxt_wbin);
  wire          nxt_full  = nxt_wgray == {~rq2_ff[AW:AW-1], rq2_ff[AW-2:0]};
  wire [AW:0]   nxt_rbin  = rbin_ff + {{AW{1'b0}}, do_rd};
  wire [AW:0]   nxt_rgray = gray(nxt_rbin);

  assign rdata = mem[rbin_ff[AW-1:0]];

  always_ff @(posedge wclk) begin
    if (do_wr) begin
      mem[wbin_ff[AW-1:0]] <= wdata;
    end
  end

  always_ff @(posedge wclk or negedge wrst_n) begin
    if (!wrst_n) begin
      wbin_ff  <= '0;
      wgray_ff <= '0;
      rq1_ff   <= '0;
      rq2_ff   <= '0;
      wrdy     <= 1'b0;
    end else if (wce) begin
      wbin_ff  <= nxt_wbin;
      wgray_ff <= nxt_wgray;
      rq1_ff   <= rgray_ff;
      rq2_ff   <= rq1_ff;
      wrdy     <= ~nxt_full;
    end
  end

  always_ff @(posedge rclk or negedge rrst_n) begin
    if (!rrst_n) begin
      rbin_ff  <= '0;
      rgray_ff <= '0;
      wq1_ff   <= '0;
      wq2_ff   <= '0;
      rvalid   <= 1'b0;
    end else if (rce) begin
      rbin_ff  <= nxt_rbin;
      rgray_ff <= nxt_rgray;
      wq1_ff   <= wgray_ff;
      wq2_ff   <= wq1_ff;
      rvalid   <= nxt_rgray != wq2_ff;
    end
  end
endmodule // mmsp_afifo

// ------------------------------------------------------------------
// Port top
// ------------------------------------------------------------------
module mmsp_port import mmsp_pkg::*; #(
  parameter int DEPTH_AW = FIFO_AW
) (
  input  wire logic                mclk,
  input  wire logic                rst_n,
  input  wire logic                clk_en,
  input  wire logic                external_phy_select,
  input  wire logic                tx_valid,
  input  wire logic [NIB_W-1:0]    tx_nib,
  output logic                     tx_ready,
  output logic                     rx_valid,
  output mmsp_rx_word_t            rx_word,
  input  wire logic                rx_ready,
  output logic                     col_status,
  output logic                     crs_status,
  input  wire logic                mgmt_valid,
  input  wire logic                mgmt_drive,
  input  wire logic                mgmt_wbit,
  output logic                     mgmt_ready,
  output logic                     mgmt_rvalid,
  output logic                     mgmt_rbit,
  input  wire logic                rom_access,
  input  wire logic [ROM_HI_W-1:0] boot_rom_address,
  input  wire logic                col_i,
  input  wire logic                crs_i,
  output logic                     mdc_o,
  output logic                     mdc_oe,
  input  wire logic                mdio_i,
  output logic                     mdio_o,
  output logic                     mdio_oe,
  input  wire logic                rx_clk,
  input  wire logic [NIB_W-1:0]    rxd_i,
  output logic [NIB_W-1:0]         rxd_o,
  output logic [NIB_W-1:0]         rxd_oe,
  input  wire logic                rx_dv_i,
  output logic                     rx_dv_o,
  output logic                     rx_dv_oe,
  input  wire logic                rx_er_i,
  output logic                     rx_er_o,
  output logic                     rx_er_oe,
  output logic                     receive_path_output_enable,
  output logic                     receive_path_output_enable_oe,
  input  wire logic                tx_clk,
  output logic [NIB_W-1:0]         txd_o,
  output logic [NIB_W-1:0]         txd_oe,
  output logic                     tx_en_o,
  output logic                     tx_en_oe
);
  if (MDC_HALF < 1 || MDC_HALF > 255) begin : g_chk
    $error("mmsp_port management half period out of range");
  end

  localparam logic [MDC_CNT_W-1:0] MDC_LAST = MDC_CNT_W'(MDC_HALF - 1);

  // ------------------------------------------------------------------
  // Reset release per link domain
  // ------------------------------------------------------------------
  logic [1:0] trst_ff, rrst_ff;
  wire        tx_rst_n = trst_ff[1];
  wire        rx_rst_n = rrst_ff[1];

  always_ff @(posedge tx_clk or negedge rst_n) begin
    if (!rst_n) trst_ff <= 2'h0;
    else        trst_ff <= {trst_ff[0], 1'b1};
  end

  always_ff @(posedge rx_clk or negedge rst_n) begin
    if (!rst_n) rrst_ff <= 2'h0;
    else        rrst_ff <= {rrst_ff[0], 1'b1};
  end

  // ------------------------------------------------------------------
  // Transmit clock domain
  // ------------------------------------------------------------------
  logic [3:0]       ts1_ff, ts2_ff;
  logic [NIB_W-1:0] txd_ff;
  logic             tx_en_ff, txd_oe_ff, tx_en_oe_ff;
  logic [NIB_W-1:0] tf_rdata;
  logic             tf_rvalid;
  wire              ext_t = ts2_ff[3];
  wire              rom_t = ts2_ff[2];
  wire              tx_pop = tf_rvalid & ext_t & ~rom_t;

  // Address is held steady by the ROM engine, so the synced qualifier is enough to capture it
  wire [NIB_W-1:0]  nxt_txd = rom_t ? boot_rom_address[ROM_TXD_LSB +: NIB_W] :
                              (tx_pop ? tf_rdata : '0);

  always_ff @(posedge tx_clk or negedge tx_rst_n) begin
    if (!tx_rst_n) begin
      ts1_ff <= 4'h0;
      ts2_ff <= 4'h0;
    end else begin
      ts1_ff <= {external_phy_select, rom_access, col_i, crs_i};
      ts2_ff <= ts1_ff;
    end
  end

  always_ff @(posedge tx_clk or negedge tx_rst_n) begin
    if (!tx_rst_n) begin
      txd_ff      <= '0;
      tx_en_ff    <= 1'b0;
      txd_oe_ff   <= 1'b0;
      tx_en_oe_ff <= 1'b0;
    end else begin
      txd_ff      <= nxt_txd;
      tx_en_ff    <= tx_pop;
      txd_oe_ff   <= ext_t | rom_t;
      tx_en_oe_ff <= ext_t;
    end
  end

  assign txd_o    = txd_ff;
  assign txd_oe   = {NIB_W{txd_oe_ff}};
  assign tx_en_o  = tx_en_ff;
  assign tx_en_oe = tx_en_oe_ff;

  mmsp_afifo #(.W(NIB_W), .AW(DEPTH_AW)) u_tx_fifo (
    .wclk   (mclk),
    .wrst_n (rst_n),
    .wce    (clk_en),
    .wen    (tx_valid),
    .wdata  (tx_nib),
    .wrdy   (tx_ready),
    .rclk   (tx_clk),
    .rrst_n (tx_rst_n),
    .rce    (1'b1),
    .ren    (tx_pop),
    .rdata  (tf_rdata),
    .rvalid (tf_rvalid)
  );

  // ------------------------------------------------------------------
  // Receive clock domain
  // ------------------------------------------------------------------
  logic [1:0]       rs1_ff, rs2_ff;
  logic [NIB_W-1:0] rxd_q_ff;
  logic             rx_dv_q_ff, rx_er_q_ff, rx_dv_d_ff;
  logic             rf_wrdy;
  wire              rx_wen = rs2_ff[1] & ~rs2_ff[0] & (rx_dv_q_ff | rx_dv_d_ff);
  // A word after the last valid nibble marks the frame end
  wire [RX_WORD_W-1:0] rx_wword = {~rx_dv_q_ff, rx_er_q_ff & rx_dv_q_ff,
                                   rxd_q_ff & {NIB_W{rx_dv_q_ff}}};

  always_ff @(posedge rx_clk or negedge rx_rst_n) begin
    if (!rx_rst_n) begin
      rs1_ff     <= 2'h0;
      rs2_ff     <= 2'h0;
      rxd_q_ff   <= '0;
      rx_dv_q_ff <= 1'b0;
      rx_er_q_ff <= 1'b0;
      rx_dv_d_ff <= 1'b0;
    end else begin
      rs1_ff     <= {external_phy_select, rom_access};
      rs2_ff     <= rs1_ff;
      rxd_q_ff   <= rxd_i;
      rx_dv_q_ff <= rx_dv_i;
      rx_er_q_ff <= rx_er_i;
      rx_dv_d_ff <= rx_dv_q_ff;
    end
  end

  // ------------------------------------------------------------------
  // System clock domain: receive buffer
  // ------------------------------------------------------------------
  mmsp_rx_word_t rf_rdata, rd0_ff, rd1_ff;
  logic          rf_rvalid, rv0_ff, rv1_ff;
  wire           rx_pop  = rv0_ff & rx_ready;
  wire           rx_push = rf_rvalid & ~rv1_ff;

  mmsp_afifo #(.W(RX_WORD_W), .AW(DEPTH_AW)) u_rx_fifo (
    .wclk   (rx_clk),
    .wrst_n (rx_rst_n),
    .wce    (1'b1),
    .wen    (rx_wen),
    .wdata  (rx_wword),
    .wrdy   (rf_wrdy),
    .rclk   (mclk),
    .rrst_n (rst_n),
    .rce    (clk_en),
    .ren    (rx_push),
    .rdata  (rf_rdata),
    .rvalid (rf_rvalid)
  );

  always_ff @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      rv0_ff <= 1'b0;
      rv1_ff <= 1'b0;
      rd0_ff <= '0;
      rd1_ff <= '0;
    end else if (clk_en) begin
      if (rx_pop) begin
        rv0_ff <= rv1_ff | rx_push;
        rd0_ff <= rv1_ff ? rd1_ff : rf_rdata;
        rv1_ff <= rv1_ff & rx_push;
        if (rv1_ff & rx_push) rd1_ff <= rf_rdata;
      end else if (rx_push) begin
        if (rv0_ff) begin
          rv1_ff <= 1'b1;
          rd1_ff <= rf_rdata;
        end else begin
          rv0_ff <= 1'b1;
          rd0_ff <= rf_rdata;
        end
      end
    end
  end

  assign rx_valid = rv0_ff;
  assign rx_word  = rd0_ff;

  // ------------------------------------------------------------------
  // System clock domain: status, ROM pins, management engine
  // ------------------------------------------------------------------
  logic [2:0]          ms1_ff, ms2_ff;
  logic                rom_oe_ff, rxpoe_ff, rxpoe_oe_ff, mdc_oe_ff;
  logic [ROM_HI_W-1:0] rom_q_ff;
  mmsp_mgmt_state_t    mg_state_ff;
  logic [MDC_CNT_W-1:0] mg_cnt_ff;
  logic                mdc_ff, mdio_o_ff, mdio_oe_ff, mg_rdy_ff, mg_rv_ff, mg_rb_ff;
  wire                 mg_accept = mgmt_valid & mg_rdy_ff;
  wire                 half_done = mg_cnt_ff == MDC_LAST;

  always_ff @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      ms1_ff      <= 3'h0;
      ms2_ff      <= 3'h0;
      rom_oe_ff   <= 1'b0;
      rom_q_ff    <= '0;
      rxpoe_ff    <= RXPOE_IDLE;
      rxpoe_oe_ff <= 1'b0;
      mdc_oe_ff   <= 1'b0;
    end else if (clk_en) begin
      ms1_ff      <= {ts2_ff[1], ts2_ff[0], mdio_i};
      ms2_ff      <= ms1_ff;
      rom_oe_ff   <= rom_access;
      rom_q_ff    <= boot_rom_address;
      rxpoe_ff    <= ~rom_access;
      rxpoe_oe_ff <= external_phy_select;
      mdc_oe_ff   <= external_phy_select;
    end
  end

  always_ff @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      mg_state_ff <= MG_IDLE;
      mg_cnt_ff   <= '0;
      mdc_ff      <= 1'b0;
      mdio_o_ff   <= 1'b0;
      mdio_oe_ff  <= 1'b0;
      mg_rdy_ff   <= 1'b1;
      mg_rv_ff    <= 1'b0;
      mg_rb_ff    <= 1'b0;
    end else if (clk_en) begin
      mg_rv_ff <= 1'b0;
      case (mg_state_ff)
        MG_IDLE: if (mg_accept) begin
          mg_state_ff <= MG_LOW;
          mg_cnt_ff   <= '0;
          mg_rdy_ff   <= 1'b0;
          mdio_o_ff   <= mgmt_wbit;
          mdio_oe_ff  <= mgmt_drive & external_phy_select;
        end
        MG_LOW: if (half_done) begin
          mg_state_ff <= MG_HIGH;
          mg_cnt_ff   <= '0;
          mdc_ff      <= 1'b1;
        end else begin
          mg_cnt_ff   <= mg_cnt_ff + 1'b1;
        end
        MG_HIGH: if (half_done) begin
          mg_state_ff <= MG_IDLE;
          mdc_ff      <= 1'b0;
          mdio_oe_ff  <= 1'b0;
          mg_rb_ff    <= ms2_ff[0];
          mg_rv_ff    <= 1'b1;
          mg_rdy_ff   <= 1'b1;
        end else begin
          mg_cnt_ff   <= mg_cnt_ff + 1'b1;
        end
        default: mg_state_ff <= MG_IDLE;
      endcase
      // Deselecting mid-slot must still let go of the shared line at once
      if (!external_phy_select) mdio_oe_ff <= 1'b0;
    end
  end

  assign col_status    = ms2_ff[2];
  assign crs_status    = ms2_ff[1];
  assign rxd_o         = rom_q_ff[ROM_RXD_LSB +: NIB_W];
  assign rx_er_o       = rom_q_ff[ROM_RXER_BIT];
  assign rx_dv_o       = rom_q_ff[ROM_RXDV_BIT];
  assign rxd_oe        = {NIB_W{rom_oe_ff}};
  assign rx_er_oe      = rom_oe_ff;
  assign rx_dv_oe      = rom_oe_ff;
  assign receive_path_output_enable    = rxpoe_ff;
  assign receive_path_output_enable_oe = rxpoe_oe_ff;
  assign mdc_o         = mdc_ff;
  assign mdc_oe        = mdc_oe_ff;
  assign mdio_o        = mdio_o_ff;
  assign mdio_oe       = mdio_oe_ff;
  assign mgmt_ready    = mg_rdy_ff;
  assign mgmt_rvalid   = mg_rv_ff;
  assign mgmt_rbit     = mg_rb_ff;

  // ------------------------------------------------------------------
  // Assertions
  // ------------------------------------------------------------------
  logic       mdc_d_ff;
  logic [7:0] mdc_gap_ff;

  always_ff @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      mdc_d_ff   <= 1'b0;
      mdc_gap_ff <= 8'h00;
    end else begin
      mdc_d_ff   <= mdc_ff;
      mdc_gap_ff <= (mdc_ff != mdc_d_ff) ? 8'h01 :
                    ((mdc_gap_ff == 8'hff) ? mdc_gap_ff : mdc_gap_ff + 8'h01);
    end
  end

  property p_mdc_rate;
    @(posedge mclk) disable iff (!rst_n) (mdc_ff != mdc_d_ff) |-> mdc_gap_ff >= MDC_HALF;
  endproperty
  a_mdc_rate: assert property (p_mdc_rate) else $error("management clock too fast");

  property p_mdio_turn;
    @(posedge mclk) disable iff (!rst_n) $rose(mdio_oe_ff) |-> !mdc_ff ##1 !mdc_ff;
  endproperty
  a_mdio_turn: assert property (p_mdio_turn) else $error("data line driven off low phase");

  property p_rxpoe;
    @(posedge mclk) disable iff (!rst_n) (rom_access && clk_en) |=> !rxpoe_ff;
  endproperty
  a_rxpoe: assert property (p_rxpoe) else $error("PHY not released during ROM access");

  property p_rom_addr;
    @(posedge mclk) disable iff (!rst_n)
      (rom_access && clk_en) |=> rx_dv_oe && {rx_dv_o, rx_er_o, rxd_o} == $past(boot_rom_address[5:0]);
  endproperty
  a_rom_addr: assert property (p_rom_addr) else $error("ROM address missing on receive pins");

  property p_tx_frame;
    @(posedge tx_clk) disable iff (!tx_rst_n)
      tx_pop |=> tx_en_ff && txd_ff == $past(tf_rdata);
  endproperty
  a_tx_frame: assert property (p_tx_frame) else $error("transmit nibble not launched");

  property p_tx_gap;
    @(posedge tx_clk) disable iff (!tx_rst_n) tx_en_ff |-> $past(tx_pop) && !$past(rom_t);
  endproperty
  a_tx_gap: assert property (p_tx_gap) else $error("enable without frame data");

  property p_release;
    @(posedge mclk) disable iff (!rst_n)
      (!external_phy_select && clk_en)[*2] |-> !mdc_oe && !mdio_oe && !receive_path_output_enable_oe;
  endproperty
  a_release: assert property (p_release) else $error("port driven while not selected");

  property p_col_sync;
    @(posedge tx_clk) disable iff (!tx_rst_n) ##2 (ts2_ff[1] == $past(col_i, 2));
  endproperty
  a_col_sync: assert property (p_col_sync) else $error("collision not two stages deep");

  property p_rx_sample;
    @(posedge rx_clk) disable iff (!rx_rst_n)
      (rx_wen && rx_dv_q_ff) |-> rx_wword[NIB_W-1:0] == $past(rxd_i) && !rx_wword[RX_WORD_W-1];
  endproperty
  a_rx_sample: assert property (p_rx_sample) else $error("receive nibble not sampled");

  c_tx_frame: cover property (@(posedge tx_clk) disable iff (!tx_rst_n) tx_en_ff [*4]);
  c_rx_eof:   cover property (@(posedge rx_clk) disable iff (!rx_rst_n) rx_wen && rx_wword[5]);
  c_mg_read:  cover property (@(posedge mclk) disable iff (!rst_n) mg_rv_ff && !mdio_oe_ff);
  c_rom:      cover property (@(posedge mclk) disable iff (!rst_n) rom_oe_ff && !rxpoe_ff);
endmodule // mmsp_port

// >>> verif/mmsp_phy_model.sv
// Behavioural external PHY: free-running link clocks, receive frames, line status, management data
`timescale 1ns/1ps
module mmsp_phy_model import mmsp_pkg::*; (
  output logic             rx_clk,
  output logic             tx_clk,
  output logic [NIB_W-1:0] rxd_i,
  output logic             rx_dv_i,
  output logic             rx_er_i,
  output logic             col_i,
  output logic             crs_i,
  output logic             mdio_i,
  input  wire logic        mdio_o,
  input  wire logic        mdio_oe
);
  logic md_bit;

  initial begin
    tx_clk  = 1'b0;
    rx_clk  = 1'b0;
    rxd_i   = 4'h5;
    rx_dv_i = 1'b0;
    rx_er_i = 1'b0;
    col_i   = 1'b0;
    crs_i   = 1'b0;
    md_bit  = 1'b1;
  end

  // Clocks run even outside frames and in reset; rx_clk is offset from tx_clk and from mclk, tx_clk starts with mclk
  always #3 tx_clk = ~tx_clk;
  initial begin
    #1.7;
    forever #3 rx_clk = ~rx_clk;
  end

  // The shared line: whoever has not released it sets its level
  assign mdio_i = mdio_oe ? mdio_o : md_bit;

  // Called at arbitrary times, with no reference to any clock
  task automatic line(input logic c, input logic s);
    col_i = c;
    crs_i = s;
  endtask

  task automatic rx_frame(input logic [11:0] nibs, input logic [2:0] errs);
    for (int i = 0; i < 3; i++) begin
      @(posedge rx_clk);
      rxd_i   <= nibs[4*i +: 4];
      rx_dv_i <= 1'b1;
      rx_er_i <= errs[i];
    end
    @(posedge rx_clk);
    // Outside the frame the data lines carry junk, not the last nibble
    rxd_i   <= ~nibs[11:8];
    rx_dv_i <= 1'b0;
    rx_er_i <= 1'b0;
  endtask
endmodule // mmsp_phy_model

// >>> verif/tb_top.sv
// Self-checking bench of the MAC-side media independent port
`timescale 1ns/1ps
module tb_top import mmsp_pkg::*; ;
  logic mclk = 1'b0, rst_n = 1'b0, clk_en = 1'b1, external_phy_select = 1'b0, rx_ready = 1'b1;
  logic tx_valid = 1'b0, mgmt_valid = 1'b0, mgmt_drive = 1'b0, mgmt_wbit = 1'b0, rom_access = 1'b0;
  logic [NIB_W-1:0] tx_nib = 4'h0, rxd_i, rxd_o, rxd_oe, txd_o, txd_oe;
  logic [ROM_HI_W-1:0] boot_rom_address = 10'h000;
  logic tx_ready, rx_valid, col_status, crs_status, mgmt_ready, mgmt_rvalid, mgmt_rbit, col_i;
  logic crs_i, mdc_o, mdc_oe, mdio_i, mdio_o, mdio_oe, rx_clk, tx_clk, rx_dv_i, rx_dv_o;
  logic rx_dv_oe, rx_er_i, rx_er_o, rx_er_oe, receive_path_output_enable, tx_en_o, tx_en_oe;
  logic receive_path_output_enable_oe;
  mmsp_rx_word_t    rx_word;
  mmsp_rx_word_t    rx_q[$];
  logic [NIB_W-1:0] tx_q[$];
  logic [31:0]      seed = 32'h266372a4;
  int               miscompares = 0, checks = 0, cycles = 0, n, hi;

  mmsp_port mmsp_port_inst (.mclk, .rst_n, .clk_en, .external_phy_select, .tx_valid, .tx_nib,
    .tx_ready, .rx_valid, .rx_word, .rx_ready, .col_status, .crs_status, .mgmt_valid, .mgmt_drive,
    .mgmt_wbit, .mgmt_ready, .mgmt_rvalid, .mgmt_rbit, .rom_access, .boot_rom_address, .col_i,
    .crs_i, .mdc_o, .mdc_oe, .mdio_i, .mdio_o, .mdio_oe, .rx_clk, .rxd_i, .rxd_o, .rxd_oe,
    .rx_dv_i, .rx_dv_o, .rx_dv_oe, .rx_er_i, .rx_er_o, .rx_er_oe, .receive_path_output_enable,
    .receive_path_output_enable_oe, .tx_clk, .txd_o, .txd_oe, .tx_en_o, .tx_en_oe);
  mmsp_phy_model mmsp_phy_model_inst (.rx_clk, .tx_clk, .rxd_i, .rx_dv_i, .rx_er_i, .col_i,
    .crs_i, .mdio_i, .mdio_o, .mdio_oe);

  always #5 mclk = ~mclk;

  function automatic logic [31:0] lfsr(input logic [31:0] s);
    return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
  endfunction

  task automatic cmp(input string what, input logic [15:0] exp, input logic [15:0] got);
    checks++;
    if (got !== exp) begin
      miscompares++;
      $display("[FAIL] %s exp=%h got=%h", what, exp, got);
    end
  endtask

  task automatic cmp_word(input mmsp_rx_word_t exp, input mmsp_rx_word_t got);
    checks++;
    if (got !== exp) begin
      miscompares++;
      $display("[FAIL] rx_word exp=%h got=%h", exp, got);
    end
  endtask

  task automatic close_out();
    $display("checks=%0d miscompares=%0d", checks, miscompares);
    if (miscompares == 0 && checks > 0) begin
      $display("RESULT: PASS");
    end else begin
      $display("RESULT: FAIL");
    end
    $finish;
  endtask

  // ------------------------------------------------------------------
  // Observers: oldest note against each result
  // ------------------------------------------------------------------
  always @(posedge tx_clk) begin
    if (tx_en_o === 1'b1) begin
      cmp("txd_o", tx_q.size() ? tx_q.pop_front() : 'x, txd_o);
    end
  end

  always @(posedge mclk) begin
    if (rx_valid === 1'b1 && rx_ready === 1'b1) begin
      cmp_word(rx_q.size() ? rx_q.pop_front() : 'x, rx_word);
    end
    cycles++;
    if (cycles == 20000) begin
      miscompares++;
      close_out();
    end
  end

  // ------------------------------------------------------------------
  // Main sequence
  // ------------------------------------------------------------------
  initial begin
    repeat (10) @(posedge mclk);
    rst_n <= 1'b1;
    repeat (3) @(negedge mclk);
    cmp("oe idle", 16'h1, {txd_oe, tx_en_oe, rxd_oe, rx_dv_oe, rx_er_oe, mdc_oe,
      mdio_oe, receive_path_output_enable_oe, receive_path_output_enable});
    // Deselected, nothing is popped, so the buffer fills until it refuses
    @(posedge mclk);
    tx_valid <= 1'b1;
    tx_nib   <= seed[3:0];
    repeat (12) @(posedge mclk) begin
      if (tx_ready === 1'b1) begin
        tx_q.push_back(tx_nib);
        seed = lfsr(seed);
        tx_nib <= seed[3:0];
      end
    end
    tx_valid <= 1'b0;
    cmp("tx depth", 16'd4, 16'(tx_q.size()));
    external_phy_select <= 1'b1;
    n = 0;
    while (tx_q.size() != 0 && n < 200) begin
      @(posedge mclk);
      n++;
    end
    cmp("tx drained", 16'h0, 16'(tx_q.size()));
    cmp("oe selected", 16'h7f, {txd_oe, mdc_oe, tx_en_oe, receive_path_output_enable_oe});
    $display("test transmit done");
    // Receiver stalls through the whole frame, then drains with random stalls
    rx_ready <= 1'b0;
    seed = lfsr(seed);
    for (int i = 0; i < 3; i++) begin
      rx_q.push_back('{1'b0, i == 1, seed[4*i +: 4]});
    end
    rx_q.push_back('{1'b1, 1'b0, 4'h0});
    mmsp_phy_model_inst.rx_frame(seed[11:0], 3'b010);
    repeat (10) @(posedge mclk);
    repeat (60) @(posedge mclk) begin
      seed = lfsr(seed);
      rx_ready <= seed[0];
    end
    rx_ready <= 1'b1;
    repeat (5) @(posedge mclk);
    cmp("rx drained", 16'h0, 16'(rx_q.size()));
    $display("test receive done");
    // One write slot, then one read slot
    for (int k = 0; k < 2; k++) begin
      seed = lfsr(seed);
      mmsp_phy_model_inst.md_bit = seed[0];
      @(posedge mclk);
      mgmt_valid <= 1'b1;
      mgmt_drive <= (k == 0);
      mgmt_wbit  <= seed[1];
      @(posedge mclk);
      mgmt_valid <= 1'b0;
      n  = 0;
      hi = 0;
      while (mgmt_rvalid !== 1'b1 && n < 100) begin
        @(negedge mclk);
        n++;
        if (mdc_o === 1'b1) hi++;
        if (n == 2 && k == 0) cmp("mdio drive", {1'b1, seed[1]}, {mdio_oe, mdio_o});
        if (n == 2) cmp("mgmt busy", 16'h0, 16'(mgmt_ready));
      end
      cmp("slot length", 16'(2 * MDC_HALF + 1), 16'(n));
      cmp("mdc high", 16'(MDC_HALF), 16'(hi));
      cmp("mgmt ready", 16'h1, 16'(mgmt_ready));
      if (k == 1) cmp("mdio read", seed[0], mgmt_rbit);
    end
    $display("test management done");
    seed = lfsr(seed);
    @(posedge mclk);
    rom_access       <= 1'b1;
    boot_rom_address <= seed[9:0];
    repeat (2) @(posedge mclk);
    @(negedge mclk);
    cmp("rom rx pins", seed[5:0], {rx_dv_o, rx_er_o, rxd_o});
    cmp("rom release", 16'h1f, {receive_path_output_enable, rxd_oe, rx_dv_oe});
    repeat (6) @(negedge mclk);
    cmp("rom tx pins", {seed[9:6], 1'b0}, {txd_o, tx_en_o});
    @(posedge mclk);
    rom_access <= 1'b0;
    $display("test boot rom done");
    #2.3 mmsp_phy_model_inst.line(1'b1, 1'b1);
    repeat (8) @(negedge mclk);
    cmp("col crs", 16'h3, {col_status, crs_status});
    mmsp_phy_model_inst.line(1'b0, 1'b0);
    repeat (8) @(negedge mclk);
    cmp("col crs", 16'h0, {col_status, crs_status});
    @(posedge mclk);
    external_phy_select <= 1'b0;
    repeat (12) @(negedge mclk);
    cmp("oe off", 16'h0, {txd_oe, tx_en_oe, mdc_oe, mdio_oe, receive_path_output_enable_oe});
    $display("test status and release done");
    close_out();
  end
endmodule // tb_top
